// ==== design/gpx_pkg.sv ====
// Package of constants and carrier types for the GPIO port with external interrupt
package gpx_pkg;
   localparam int          GPX_PINS        = 8;
   localparam logic [11:0] GPX_OFF_DATA    = 12'h000;
   localparam logic [11:0] GPX_OFF_DIR     = 12'h004;
   localparam logic [11:0] GPX_OFF_OPT     = 12'h008;
   localparam logic [11:0] GPX_OFF_SENS    = 12'h00C;
   localparam logic [11:0] GPX_OFF_IRQEN   = 12'h010;
   localparam logic [11:0] GPX_OFF_LATCH   = 12'h014;
   localparam logic [7:0]  GPX_RST_DATA    = 8'h00;
   localparam logic [7:0]  GPX_RST_DIR     = 8'h00;
   localparam logic [7:0]  GPX_RST_OPT     = 8'h00;
   localparam logic [1:0]  GPX_RST_SENS    = 2'h0;
   localparam logic [7:0]  GPX_RST_IRQEN   = 8'hFF;
   localparam logic [1:0]  GPX_SENS_FALL_LOW = 2'h0;
   localparam logic [1:0]  GPX_SENS_RISE     = 2'h1;
   localparam logic [1:0]  GPX_SENS_FALL     = 2'h2;
   localparam logic [1:0]  GPX_SENS_BOTH     = 2'h3;

   // Alternate function request for all pins
   typedef struct packed {
      logic [7:0] out_en;
      logic [7:0] out_val;
      logic [7:0] out_od;
      logic [7:0] in_en;
   } gpx_alt_t;

   // Pad control towards the pins
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] pull_up;
   } gpx_pad_t;

   typedef enum logic [1:0] {
      GPX_IDLE  = 2'b00,
      GPX_DATA  = 2'b01
   } gpx_bus_st_t;
endpackage

// ==== design/gpx_pin_cell.sv ====
// Per-pin mode decode and alternate function override
`timescale 1ns/100ps
module gpx_pin_cell
   import gpx_pkg::*;
(
   input  wire logic dir,
   input  wire logic opt,
   input  wire logic latch,
   input  wire logic pin_in,
   input  wire logic alt_out_en,
   input  wire logic alt_out_val,
   input  wire logic alt_od,
   input  wire logic alt_in_en,
   output logic      drive_low,
   output logic      drive_high,
   output logic      pull_up,
   output logic      read_val,
   output logic      alt_in_val,
   output logic      irq_pin
);
   logic out_mode;
   logic push_pull;
   logic val;

   // Peripheral output forces output mode and its own drive type
   always_comb begin
      out_mode   = alt_out_en | dir;
      push_pull  = alt_out_en ? ~alt_od : opt;
      val        = alt_out_en ? alt_out_val : latch;
      drive_low  = out_mode & ~val;
      drive_high = out_mode & val & push_pull;
      pull_up    = ~out_mode & opt & ~alt_in_en;
      irq_pin    = ~dir & opt & ~alt_out_en;
      if (dir) begin
         read_val = latch;
      end else if (alt_out_en) begin
         read_val = alt_out_val;
      end else begin
         read_val = pin_in;
      end
      alt_in_val = dir ? latch : pin_in;
   end
endmodule // gpx_pin_cell

// ==== design/gpx_edge_det.sv ====
// Sensitivity-based event detection for one interrupt group
`timescale 1ns/100ps
module gpx_edge_det
   import gpx_pkg::*;
#(
   parameter int N = GPX_PINS
)(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [N-1:0] pin_in,
   input  wire logic [N-1:0] enable,
   input  wire logic [1:0]   sens,
   output logic              event_any
);
   logic [N-1:0] prev_q;
   logic [N-1:0] hit;

   // Previous level for edge compare
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q <= '1;
      end else begin
         prev_q <= pin_in;
      end
   end

   // Detect per pin first, then OR
   for (genvar i = 0; i < N; i++) begin : g_pin
      always_comb begin
         case (sens)
            GPX_SENS_FALL_LOW: hit[i] = ~pin_in[i];
            GPX_SENS_RISE:     hit[i] = pin_in[i] & ~prev_q[i];
            GPX_SENS_FALL:     hit[i] = ~pin_in[i] & prev_q[i];
            default:           hit[i] = pin_in[i] ^ prev_q[i];
         endcase
      end
   end
   assign event_any = |(hit & enable);
endmodule // gpx_edge_det

// ==== design/gpx_port.sv ====
// Eight-pin GPIO port with external interrupt request, AHB-Lite slave
`timescale 1ns/100ps
module gpx_port
   import gpx_pkg::*;
#(
   parameter int N = GPX_PINS
)(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic [31:0]       hrdata,
   output logic              hreadyout,
   output logic              hresp,
   input  wire logic [N-1:0] pin_in,
   output gpx_pad_t          pad_q,
   input  wire gpx_alt_t     alt,
   output logic [N-1:0]      alt_in_q,
   input  wire logic         vector_fetch,
   output logic              ext_irq_q
);
   logic [N-1:0] data_q;
   logic [N-1:0] dir_q;
   logic [N-1:0] opt_q;
   logic [1:0]   sens_q;
   logic [N-1:0] irqen_q;
   logic         wr_pend_q;
   logic [11:0]  addr_q;
   logic [N-1:0] drive_low;
   logic [N-1:0] drive_high;
   logic [N-1:0] pull_up;
   logic [N-1:0] read_val;
   logic [N-1:0] alt_in_val;
   logic [N-1:0] irq_pin;
   logic         event_any;
   logic         sens_wr;
   logic         sens_change;
   logic         access;

   assign access  = hsel & hready & htrans[1];
   assign sens_wr = wr_pend_q & (addr_q == GPX_OFF_SENS);
   assign sens_change = sens_wr & (hwdata[1:0] != sens_q);

   // One mode cell per pin; bit X steers pin X only
   for (genvar i = 0; i < N; i++) begin : g_cell
      gpx_pin_cell u_cell (
         .dir         (dir_q[i]),
         .opt         (opt_q[i]),
         .latch       (data_q[i]),
         .pin_in      (pin_in[i]),
         .alt_out_en  (alt.out_en[i]),
         .alt_out_val (alt.out_val[i]),
         .alt_od      (alt.out_od[i]),
         .alt_in_en   (alt.in_en[i]),
         .drive_low   (drive_low[i]),
         .drive_high  (drive_high[i]),
         .pull_up     (pull_up[i]),
         .read_val    (read_val[i]),
         .alt_in_val  (alt_in_val[i]),
         .irq_pin     (irq_pin[i])
      );
   end

   gpx_edge_det #(.N(N)) u_det (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .pin_in    (pin_in),
      .enable    (irq_pin & irqen_q),
      .sens      (sens_q),
      .event_any (event_any)
   );

   // Address phase capture; slave is always ready with zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 12'h000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend_q <= access & hwrite;
         if (access) begin
            addr_q <= haddr[11:0];
         end
         // Response is always OKAY; kept in a flop so every bus output is registered
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Read data registered at address phase so hrdata stands from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (access && !hwrite) begin
         case (haddr[11:0])
            GPX_OFF_DATA:  hrdata <= {24'h000000, read_val};
            GPX_OFF_DIR:   hrdata <= {24'h000000, dir_q};
            GPX_OFF_OPT:   hrdata <= {24'h000000, opt_q};
            GPX_OFF_SENS:  hrdata <= {30'h00000000, sens_q};
            GPX_OFF_IRQEN: hrdata <= {24'h000000, irqen_q};
            default:       hrdata <= 32'h00000000;
         endcase
      end
   end

   // Register writes; data write lands in the latch whatever the mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_q  <= GPX_RST_DATA;
         dir_q   <= GPX_RST_DIR;
         opt_q   <= GPX_RST_OPT;
         sens_q  <= GPX_RST_SENS;
         irqen_q <= GPX_RST_IRQEN;
      end else if (wr_pend_q) begin
         case (addr_q)
            GPX_OFF_DATA:  data_q  <= hwdata[7:0];
            GPX_OFF_DIR:   dir_q   <= hwdata[7:0];
            GPX_OFF_OPT:   opt_q   <= hwdata[7:0];
            GPX_OFF_SENS:  sens_q  <= hwdata[1:0];
            GPX_OFF_IRQEN: irqen_q <= hwdata[7:0];
            default:       data_q  <= data_q;
         endcase
      end
   end

   // Pending latch: event wins over fetch clear; sensitivity change discards
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_irq_q <= 1'b0;
      end else if (sens_change) begin
         ext_irq_q <= 1'b0;
      end else if (event_any) begin
         ext_irq_q <= 1'b1;
      end else if (vector_fetch) begin
         ext_irq_q <= 1'b0;
      end
   end

   // Pads from flops; oe_n low while the pin is driven
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pad_q.out     <= 8'h00;
         pad_q.oe_n    <= 8'hFF;
         pad_q.pull_up <= 8'h00;
         alt_in_q      <= 8'h00;
      end else begin
         pad_q.out     <= drive_high;
         pad_q.oe_n    <= ~(drive_low | drive_high);
         pad_q.pull_up <= pull_up;
         alt_in_q      <= alt_in_val;
      end
   end

   // Assertions
   property p_pull_in_only;
      @(posedge hclk) disable iff (!hresetn)
      pad_q.pull_up != 8'h00 |-> (pad_q.oe_n & pad_q.pull_up) == pad_q.pull_up;
   endproperty
   a_pull_in_only: assert property (p_pull_in_only) else $error("pull-up on driven pin");

   property p_sens_clear;
      @(posedge hclk) disable iff (!hresetn)
      sens_change |=> !ext_irq_q;
   endproperty
   a_sens_clear: assert property (p_sens_clear) else $error("pending not cleared");

   property p_event_sets;
      @(posedge hclk) disable iff (!hresetn)
      event_any && !sens_change |=> ext_irq_q;
   endproperty
   a_event_sets: assert property (p_event_sets) else $error("event lost");

   property p_fetch_clear;
      @(posedge hclk) disable iff (!hresetn)
      ext_irq_q && vector_fetch && !event_any |=> !ext_irq_q;
   endproperty
   a_fetch_clear: assert property (p_fetch_clear) else $error("fetch did not clear");

   property p_out_drive;
      @(posedge hclk) disable iff (!hresetn)
      (dir_q[0] && opt_q[0] && !alt.out_en[0]) |=> (!pad_q.oe_n[0] && pad_q.out[0] == $past(data_q[0]));
   endproperty
   a_out_drive: assert property (p_out_drive) else $error("push-pull pin 0 wrong");

   property p_od_float;
      @(posedge hclk) disable iff (!hresetn)
      (dir_q[0] && !opt_q[0] && data_q[0] && !alt.out_en[0]) |=> pad_q.oe_n[0];
   endproperty
   a_od_float: assert property (p_od_float) else $error("open-drain high driven");

   property p_alt_force;
      @(posedge hclk) disable iff (!hresetn)
      alt.out_en[0] && !alt.out_val[0] |=> !pad_q.oe_n[0] && !pad_q.out[0];
   endproperty
   a_alt_force: assert property (p_alt_force) else $error("alternate not driving");

   property p_in_read;
      @(posedge hclk) disable iff (!hresetn)
      access && !hwrite && haddr[11:0] == GPX_OFF_DATA && !dir_q[0] && !alt.out_en[0]
         |=> hrdata[0] == $past(pin_in[0]);
   endproperty
   a_in_read: assert property (p_in_read) else $error("input read wrong");

   property p_reset_float;
      @(posedge hclk) $rose(hresetn) |-> pad_q.oe_n == 8'hFF && pad_q.pull_up == 8'h00;
   endproperty
   a_reset_float: assert property (p_reset_float) else $error("reset state wrong");

   // Data writes land in the latch whatever the pin mode
   property p_write_latch;
      @(posedge hclk) disable iff (!hresetn)
      wr_pend_q && addr_q == GPX_OFF_DATA |=> data_q == $past(hwdata[7:0]);
   endproperty
   a_write_latch: assert property (p_write_latch) else $error("latch write lost");

   // Open-drain output still pulls low for a zero
   property p_od_low;
      @(posedge hclk) disable iff (!hresetn)
      (dir_q[0] && !opt_q[0] && !data_q[0] && !alt.out_en[0]) |=> !pad_q.oe_n[0] && !pad_q.out[0];
   endproperty
   a_od_low: assert property (p_od_low) else $error("open-drain low not driven");

   // Output pin reads back the latch, not the pad
   property p_out_read;
      @(posedge hclk) disable iff (!hresetn)
      access && !hwrite && haddr[11:0] == GPX_OFF_DATA && dir_q[0]
         |=> hrdata[0] == $past(data_q[0]);
   endproperty
   a_out_read: assert property (p_out_read) else $error("output read wrong");

   // Input pin with a peripheral driving reads the peripheral value
   property p_alt_read;
      @(posedge hclk) disable iff (!hresetn)
      access && !hwrite && haddr[11:0] == GPX_OFF_DATA && !dir_q[0] && alt.out_en[0]
         |=> hrdata[0] == $past(alt.out_val[0]);
   endproperty
   a_alt_read: assert property (p_alt_read) else $error("alternate read wrong");

   // Peripheral input sees the latch on an output pin
   property p_alt_in_latch;
      @(posedge hclk) disable iff (!hresetn)
      dir_q[0] |=> alt_in_q[0] == $past(data_q[0]);
   endproperty
   a_alt_in_latch: assert property (p_alt_in_latch) else $error("peripheral input not latch");

   // Peripheral input sees the pin on an input pin
   property p_alt_in_pin;
      @(posedge hclk) disable iff (!hresetn)
      !dir_q[0] |=> alt_in_q[0] == $past(pin_in[0]);
   endproperty
   a_alt_in_pin: assert property (p_alt_in_pin) else $error("peripheral input not pin");

   // No interrupt pin selected means no event at all
   property p_no_pin_event;
      @(posedge hclk) disable iff (!hresetn)
      (irq_pin & irqen_q) == '0 |-> !event_any;
   endproperty
   a_no_pin_event: assert property (p_no_pin_event) else $error("event without interrupt pin");

   // One pin's falling edge alone reaches the shared request
   property p_fall_hit;
      @(posedge hclk) disable iff (!hresetn)
      sens_q == GPX_SENS_FALL && irq_pin[0] && irqen_q[0] && $fell(pin_in[0]) |-> event_any;
   endproperty
   a_fall_hit: assert property (p_fall_hit) else $error("pin event not combined");

   // Rewriting the same sensitivity keeps a pending request
   property p_sens_keep;
      @(posedge hclk) disable iff (!hresetn)
      sens_wr && !sens_change && ext_irq_q && !vector_fetch |=> ext_irq_q;
   endproperty
   a_sens_keep: assert property (p_sens_keep) else $error("pending dropped on same sensitivity");

   c_irq:   cover property (@(posedge hclk) disable iff (!hresetn) $rose(ext_irq_q));
   c_fetch: cover property (@(posedge hclk) disable iff (!hresetn) ext_irq_q ##1 vector_fetch ##1 !ext_irq_q);
   c_sens:  cover property (@(posedge hclk) disable iff (!hresetn) ext_irq_q && sens_change);
   c_alt:   cover property (@(posedge hclk) disable iff (!hresetn) alt.out_en != 8'h00);
   c_keep:  cover property (@(posedge hclk) disable iff (!hresetn) sens_wr && !sens_change && ext_irq_q);
endmodule // gpx_port

// ==== verification/gpx_board.sv ====
// Board-side pin model: resolves each pin from pad drive, board drive and pull-up
`timescale 1ns/100ps
module gpx_board
   import gpx_pkg::*;
(
   input  wire logic       hclk,
   input  wire gpx_pad_t   pad_q,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic [7:0]      lvl
);
   logic [7:0] drift_q;
   // Undriven pins wander so a floating read never looks stable
   initial drift_q = 8'h55;
   always @(posedge hclk) drift_q <= ~drift_q;
   // Pad drive wins, then the board, then the pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         lvl[i] = !pad_q.oe_n[i] ? pad_q.out[i] : ext_en[i] ? ext_val[i] : pad_q.pull_up[i] ? 1'b1 : drift_q[i];
      end
   end
endmodule // gpx_board

// ==== verification/gpio_port_with_ext_irq_bench.sv ====
// Self-checking bench for the GPIO port: bus access, pad modes, alternates, interrupt
`timescale 1ns/100ps
module gpio_port_with_ext_irq_bench;
   import gpx_pkg::*;
   logic        hclk, hresetn, hwrite, hreadyout, hresp, vector_fetch, ext_irq_q;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0]  pin_lvl, alt_in_q, ext_en, ext_val;
   gpx_pad_t    pad_q;
   gpx_alt_t    alt;
   int          bad_count, n_compared, seed, m_data, m_dir, m_opt;
   gpx_port u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pin_in(pin_lvl), .pad_q(pad_q), .alt(alt), .alt_in_q(alt_in_q), .vector_fetch(vector_fetch),
      .ext_irq_q(ext_irq_q));
   gpx_board u_board (.hclk(hclk), .pad_q(pad_q), .ext_en(ext_en), .ext_val(ext_val), .lvl(pin_lvl));
   // Clock and hang guard
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      #300000;
      bad_count++;
      report_and_stop();
   end
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One single transfer; waits on hready at both phases, no fixed latency assumed
   task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] rd);
      haddr <= {20'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // Whole-register writes taken from the model, never read-modify-write
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
      if (a == GPX_OFF_DATA) m_data = d;
      if (a == GPX_OFF_DIR) m_dir = d;
      if (a == GPX_OFF_OPT) m_opt = d;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] r;
      bus(1'b0, a, 8'h00, r);
      check(r, {24'h0, e});
      check({31'h0, hresp}, 32'h0);
   endtask
   // Expected pads, peripheral inputs and readback, worked out from the mode rules
   task automatic chk_all;
      logic [7:0] oe, pu, v, rd, ain;
      bit ae, ed, od, lv;
      for (int i = 0; i < 8; i++) begin
         ae = alt.out_en[i];
         ed = ae | m_dir[i];
         v[i] = ae ? alt.out_val[i] : m_data[i];
         od = ae ? alt.out_od[i] : !m_opt[i];
         oe[i] = !(ed && (!od || !v[i]));
         pu[i] = !ed && m_opt[i];
         lv = oe[i] ? ext_val[i] : v[i];
         ain[i] = m_dir[i] ? m_data[i] : lv;
         rd[i] = m_dir[i] ? m_data[i] : ae ? alt.out_val[i] : lv;
      end
      check({24'h0, pad_q.oe_n}, {24'h0, oe});
      check({24'h0, pad_q.pull_up}, {24'h0, pu});
      check({24'h0, pad_q.out & ~oe}, {24'h0, v & ~oe});
      check({24'h0, alt_in_q}, {24'h0, ain});
      rdc(GPX_OFF_DATA, rd);
   endtask
   task automatic fetch;
      vector_fetch <= 1'b1;
      @(posedge hclk);
      vector_fetch <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask
   initial begin
      seed = 18;
      {hresetn, hwrite, htrans, haddr, hwdata, vector_fetch, alt} = '0;
      {m_data, m_dir, m_opt} = '0;
      ext_en = 8'hFF;
      ext_val = 8'h5A;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(GPX_OFF_DIR, 8'h00);
      rdc(GPX_OFF_OPT, 8'h00);
      chk_all();
      wr(12'h020, 8'hFF);
      rdc(12'h020, 8'h00);
      // Latch written while input must not reach the pins until output is chosen
      wr(GPX_OFF_DATA, 8'hC3);
      repeat (3) @(posedge hclk);
      chk_all();
      wr(GPX_OFF_OPT, 8'hFF);
      wr(GPX_OFF_DIR, 8'hFF);
      repeat (3) @(posedge hclk);
      chk_all();
      // Random modes and alternates; software keeps pull-ups and interrupt pins off alternates
      for (int k = 0; k < 16; k++) begin
         wr(GPX_OFF_DATA, 8'($random(seed)));
         wr(GPX_OFF_DIR, 8'($random(seed)));
         wr(GPX_OFF_OPT, 8'($random(seed)));
         ext_val <= 8'($random(seed));
         // Each field cut to one byte so all four reach the carrier
         alt <= (k < 4) ? '0 : {8'($random(seed) & (m_dir | ~m_opt)), 8'($random(seed)), 8'($random(seed)),
            8'($random(seed) & ~m_opt)};
         repeat (3) @(posedge hclk);
         chk_all();
      end
      // Interrupt pins 2 and 7 enabled; only pin 2 toggled under each sensitivity
      alt <= '0;
      ext_val <= 8'hFF;
      wr(GPX_OFF_DIR, 8'h00);
      wr(GPX_OFF_OPT, 8'h84);
      for (int m = 0; m < 4; m++) begin
         wr(GPX_OFF_SENS, m[7:0]);
         fetch();
         check({31'h0, ext_irq_q}, 32'h0);
         ext_val <= 8'hFB;
         repeat (3) @(posedge hclk);
         check({31'h0, ext_irq_q}, {31'h0, m != 1});
         fetch();
         check({31'h0, ext_irq_q}, {31'h0, m == 0});
         ext_val <= 8'hFF;
         repeat (3) @(posedge hclk);
         check({31'h0, ext_irq_q}, {31'h0, m != 2});
         fetch();
         check({31'h0, ext_irq_q}, 32'h0);
      end
      // Second pin ORed in; same sensitivity keeps the request, a change drops it
      ext_val <= 8'h7F;
      repeat (3) @(posedge hclk);
      check({31'h0, ext_irq_q}, 32'h1);
      rdc(GPX_OFF_LATCH, 8'h00);
      wr(GPX_OFF_SENS, 8'h03);
      repeat (2) @(posedge hclk);
      check({31'h0, ext_irq_q}, 32'h1);
      wr(GPX_OFF_SENS, 8'h01);
      repeat (2) @(posedge hclk);
      check({31'h0, ext_irq_q}, 32'h0);
      report_and_stop();
   end
endmodule // gpio_port_with_ext_irq_bench
